// ===== rtl/l21d_pkg.sv
// Purpose: shared constants and carriers of the line 21 text display block
// Assumes: 100 MHz system clock, 12 MHz dot rate, 32-bit AXI4-Lite register bus
// Notes: offsets are byte addresses
package l21d_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DOT_HZ = 12_000_000;
  localparam logic [6:0] DOT_STEP = 7'(DOT_HZ / 1_000_000);
  localparam logic [6:0] DOT_MOD = 7'(CLK_HZ / 1_000_000);
  localparam int unsigned BOX_CENTER_NS = 13500;
  localparam logic [9:0] BOX_CENTER_DOTS = 10'(BOX_CENTER_NS * (DOT_HZ / 1_000_000) / 1000);
  localparam logic [9:0] CELL_DOTS = 10'h008;
  localparam logic [9:0] ROW_CELLS = 10'h022;
  localparam logic [9:0] BOX_DOTS = 10'h110;
  localparam logic [9:0] HPOS_STEP_DOTS = 10'h004;
  localparam logic [8:0] BOX_TOP = 9'h02b;
  localparam logic [8:0] BOX_BOT = 9'h0ed;
  localparam logic [8:0] EXP_TOP = 9'h029;
  localparam logic [8:0] EXP_BOT = 9'h0ee;
  localparam logic [8:0] ROW_LINES = 9'h00d;
  localparam logic [3:0] SCROLL_LINES = 4'hd;
  localparam logic [4:0] LAST_COL = 5'h1f;
  localparam logic [4:0] NTSC_DATA_LINE = 5'h15;
  localparam logic [4:0] PAL_DATA_LINE = 5'h16;
  localparam logic [3:0] TEXT_ROWS_RST = 4'hf;
  localparam logic [3:0] BASE_ROW_RST = 4'h0;
  localparam logic [7:0] HPOS_RST = 8'h00;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_HPOS = 32'h0000_0004;
  localparam logic [31:0] ADDR_TEXT = 32'h0000_0008;
  localparam logic [31:0] ADDR_STAT = 32'h0000_000c;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [3:0] chan;
    logic dec_on;
    logic pal;
    logic hlock_flyback;
    logic vlock_vin;
    logic blue_box;
    logic shadow;
    logic ext_attr_en;
    logic ext_chars;
    logic expand;
  } l21d_ctrl_t;
  localparam l21d_ctrl_t CTRL_RST = '0;

  // command processor events for the selected text channel
  typedef struct packed {
    logic chr;
    logic cr;
    logic start_text;
    logic resume_text;
    logic other_chan;
  } l21d_evt_t;

  // glyph and attribute answer for the addressed cell and dot
  typedef struct packed {
    logic glyph_dot;
    logic accent_dot;
    logic desc_here;
    logic [2:0] fg_color;
    logic attr_semi;
  } l21d_pix_t;
endpackage : l21d_pkg

// ===== rtl/l21d_display.sv
// Purpose: on-screen timing, cell addressing, keying and text row control
// Assumes: inputs synchronous to clk; glyph store answers combinationally
// Notes: channel 0-3 captions, 4-7 text, 8 extended data
//
// Contract
// R1: pick one of nine channels; off hides
// R2: PAL/SECAM option takes data from line 22
// R3: horizontal lock to video or flyback input
// R4: vertical lock video default, else external pulse
// R5: horizontal box position in quarter-cell steps; code steps half a cell (4 dots)
// R6: 12x18 glyph in 16x26 cell, border
// R7: alternate glyph rows and columns per field
// R8: 32 characters plus two black end cells
// R9: box from line 43 to 237, rows butted
// R10: default box centre 13.5 us after sync
// R11: black box, blue on command, all modes; code draws no box, only shadow dots, with shadow on
// R12: drop shadow two dots right and below
// R13: extended characters always; attributes user gated
// R14: semi-transparent background floats box keying output
// R15: accents in row above; descender wins
// R16: expanded box two lines above, one below
// R17: shared code space; host restores extended set
// R18: text box only while line 21 valid
// R19: text fills from top, then scrolls up
// R20: other channel halts; resume keeps pointer
// R21: start text clears, restarts row 1 col 1
// R22: text row count and base row programmable
// R23: scroll one line per frame; CR jumps
// R24: all timing from the 12 MHz dot rate
// R25: reset picks video lock, black, default position
`timescale 1ns/100ps
`default_nettype none
module l21d_display (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic video_hsync,
  input wire logic horiz_flyback_in,
  input wire logic video_vsync,
  input wire logic vert_in,
  input wire logic line21_valid,
  input wire l21d_pkg::l21d_evt_t evt,
  input wire l21d_pkg::l21d_pix_t pix,
  output logic [3:0] chan_sel,
  output logic [4:0] data_line,
  output logic charset_graphics,
  output logic [3:0] disp_row,
  output logic [5:0] disp_cell,
  output logic [4:0] glyph_row,
  output logic [3:0] glyph_col,
  output logic text_clear,
  output logic text_roll,
  output logic [2:0] rgb,
  output logic box_key_o,
  output logic box_key_oe
);
  typedef struct packed {
    l21d_pkg::l21d_ctrl_t ctrl;
    logic [7:0] hpos;
    logic [3:0] text_rows;
    logic [3:0] base_row;
    logic [6:0] acc;
    logic [9:0] dot;
    logic [8:0] line;
    logic field;
    logic hs_q;
    logic vs_q;
    logic [3:0] row;
    logic [4:0] col;
    logic halted;
    logic [3:0] scroll;
    logic clear_p;
    logic roll_p;
    logic [1:0] sh_dly;
    logic [271:0] line_buf;
    logic [2:0] rgb;
    logic key;
    logic key_oe;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } l21d_state_t;

  l21d_state_t st, next_st;
  logic dot_tick, hs_sel, vs_sel, hs_edge, vs_edge, frame_end, wr_go, rd_go;
  logic text_mode, show, in_v, in_h, in_cell, fg, shad, in_text_rows;
  logic [9:0] box_start, hx;
  logic [8:0] vtop, vbot, vy, vys;
  logic [3:0] row_num;
  logic [8:0] row_line;

  assign dot_tick = (st.acc + l21d_pkg::DOT_STEP) >= l21d_pkg::DOT_MOD; // R24
  assign hs_sel = st.ctrl.hlock_flyback ? horiz_flyback_in : video_hsync; // R3
  assign vs_sel = st.ctrl.vlock_vin ? vert_in : video_vsync; // R4
  assign hs_edge = hs_sel & ~st.hs_q;
  assign vs_edge = vs_sel & ~st.vs_q;
  assign frame_end = vs_edge & st.field;
  assign text_mode = st.ctrl.chan[3:2] == 2'h1;
  // text box only with live line 21 code; decoder off hides all
  assign show = st.ctrl.dec_on & (~text_mode | line21_valid); // R1 R18
  // centre at 13.5 us, offset in half-cell (4-dot) steps
  assign box_start = l21d_pkg::BOX_CENTER_DOTS - (l21d_pkg::BOX_DOTS >> 1)
    + 10'({{2{st.hpos[7]}}, st.hpos} * l21d_pkg::HPOS_STEP_DOTS); // R5 R10
  assign hx = st.dot - box_start;
  assign in_h = (st.dot >= box_start) && (hx < l21d_pkg::BOX_DOTS); // R8
  assign vtop = st.ctrl.expand ? l21d_pkg::EXP_TOP : l21d_pkg::BOX_TOP; // R16
  assign vbot = st.ctrl.expand ? l21d_pkg::EXP_BOT : l21d_pkg::BOX_BOT; // R16
  assign in_v = (st.line >= vtop) && (st.line <= vbot); // R9
  assign vy = st.line - l21d_pkg::BOX_TOP;
  assign vys = vy + 9'(st.scroll); // R23
  assign row_num = 4'(vys / l21d_pkg::ROW_LINES); // R9
  assign row_line = vys % l21d_pkg::ROW_LINES;
  assign in_text_rows = ~text_mode
    || ((row_num >= st.base_row) && (row_num - st.base_row < st.text_rows)); // R22
  assign in_cell = (hx[8:3] != 6'h00) && (hx[8:3] != 6'(l21d_pkg::ROW_CELLS - 10'h001)); // R8
  // accent of the row below lands here unless a descender owns the dot
  assign fg = in_cell & (pix.glyph_dot | (pix.accent_dot & ~pix.desc_here)); // R15
  assign shad = st.sh_dly[1] | st.line_buf[hx[8:0]]; // R12
  assign wr_go = awvalid & wvalid & ~st.bvalid;
  assign rd_go = arvalid & ~st.rvalid;

  always_comb
  begin
    next_st = st;
    next_st.clear_p = 1'b0;
    next_st.roll_p = 1'b0;
    next_st.hs_q = hs_sel;
    next_st.vs_q = vs_sel;
    next_st.acc = dot_tick ? 7'(st.acc + l21d_pkg::DOT_STEP - l21d_pkg::DOT_MOD)
      : 7'(st.acc + l21d_pkg::DOT_STEP); // R24
    if (hs_edge)
    begin
      next_st.dot = '0; // R3
      next_st.line = 9'(st.line + 9'h001);
    end
    else if (dot_tick)
    begin
      next_st.dot = 10'(st.dot + 10'h001);
    end
    if (vs_edge)
    begin
      next_st.line = '0; // R4
      next_st.field = ~st.field; // R7
    end
    if (frame_end && st.scroll != 4'h0)
    begin
      next_st.scroll = 4'(st.scroll - 4'h1); // R23
    end
    if (evt.start_text)
    begin
      next_st.row = st.base_row; // R21
      next_st.col = '0;
      next_st.scroll = '0;
      next_st.halted = 1'b0;
      next_st.clear_p = 1'b1; // R21
    end
    else if (evt.other_chan)
    begin
      next_st.halted = 1'b1; // R20
    end
    else if (evt.resume_text)
    begin
      next_st.halted = 1'b0; // R20
    end
    else if (!st.halted && evt.cr)
    begin
      next_st.col = '0;
      if (st.row - st.base_row < st.text_rows - 4'h1)
      begin
        next_st.row = 4'(st.row + 4'h1); // R19
      end
      else
      begin
        next_st.scroll = l21d_pkg::SCROLL_LINES; // R19 R23
        next_st.roll_p = 1'b1;
      end
    end
    else if (!st.halted && evt.chr && st.col != l21d_pkg::LAST_COL)
    begin
      next_st.col = 5'(st.col + 5'h01);
    end
    if (dot_tick)
    begin
      next_st.sh_dly = {st.sh_dly[0], fg};
      if (in_h)
      begin
        next_st.line_buf[hx[8:0]] = fg;
      end
      next_st.key_oe = 1'b1;
      next_st.key = 1'b0;
      next_st.rgb = 3'h0;
      if (show && in_h && in_v && in_text_rows)
      begin
        if (fg)
        begin
          next_st.rgb = pix.fg_color;
          next_st.key = 1'b1;
        end
        else if (st.ctrl.shadow)
        begin
          next_st.key = shad; // R12
        end
        else
        begin
          next_st.rgb = st.ctrl.blue_box ? 3'h1 : 3'h0; // R11
          next_st.key = 1'b1;
        end
        if (st.ctrl.ext_attr_en && pix.attr_semi)
        begin
          next_st.key_oe = 1'b0; // R13 R14
        end
      end
    end
    next_st.bvalid = st.bvalid & ~bready;
    next_st.rvalid = st.rvalid & ~rready;
    if (wr_go)
    begin
      next_st.bvalid = 1'b1;
      next_st.bresp = l21d_pkg::RESP_OK;
      unique case (awaddr)
        l21d_pkg::ADDR_CTRL:
        begin
          if (wstrb[0]) {next_st.ctrl.ext_chars, next_st.ctrl.dec_on, next_st.ctrl.chan}
            = {wdata[7], wdata[6], wdata[3:0]}; // R1 R17
          if (wstrb[1]) {next_st.ctrl.expand, next_st.ctrl.ext_attr_en, next_st.ctrl.shadow,
            next_st.ctrl.blue_box, next_st.ctrl.vlock_vin, next_st.ctrl.hlock_flyback,
            next_st.ctrl.pal} = wdata[14:8];
        end
        l21d_pkg::ADDR_HPOS:
        begin
          if (wstrb[0]) next_st.hpos = wdata[7:0]; // R5
        end
        l21d_pkg::ADDR_TEXT:
        begin
          if (wstrb[0]) {next_st.base_row, next_st.text_rows} = wdata[7:0]; // R22
        end
        l21d_pkg::ADDR_STAT:
        begin
          next_st.bresp = l21d_pkg::RESP_OK;
        end
        default:
        begin
          next_st.bresp = l21d_pkg::RESP_DECERR;
        end
      endcase
    end
    if (rd_go)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = l21d_pkg::RESP_OK;
      unique case (araddr)
        l21d_pkg::ADDR_CTRL: next_st.rdata = {17'h0, st.ctrl.expand, st.ctrl.ext_attr_en,
          st.ctrl.shadow, st.ctrl.blue_box, st.ctrl.vlock_vin, st.ctrl.hlock_flyback,
          st.ctrl.pal, st.ctrl.ext_chars, st.ctrl.dec_on, 2'h0, st.ctrl.chan};
        l21d_pkg::ADDR_HPOS: next_st.rdata = {24'h0, st.hpos};
        l21d_pkg::ADDR_TEXT: next_st.rdata = {24'h0, st.base_row, st.text_rows};
        l21d_pkg::ADDR_STAT: next_st.rdata = {14'h0, st.field, st.halted, st.scroll,
          3'h0, st.col, st.row};
        default:
        begin
          next_st.rdata = '0;
          next_st.rresp = l21d_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.ctrl <= l21d_pkg::CTRL_RST; // R25
      st.hpos <= l21d_pkg::HPOS_RST; // R25
      st.text_rows <= l21d_pkg::TEXT_ROWS_RST; // R19
      st.base_row <= l21d_pkg::BASE_ROW_RST;
      st.key_oe <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign awready = wr_go;
  assign wready = wr_go;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = rd_go;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign chan_sel = st.ctrl.chan; // R1
  assign data_line = st.ctrl.pal ? l21d_pkg::PAL_DATA_LINE : l21d_pkg::NTSC_DATA_LINE; // R2
  // drop shadow maps the shared codes to graphics unless host forces extended
  assign charset_graphics = st.ctrl.shadow & ~st.ctrl.ext_chars; // R17
  assign disp_row = row_num;
  assign disp_cell = hx[8:3];
  assign glyph_row = 5'({row_line[3:0], st.field}); // R6 R7
  assign glyph_col = {hx[2:0], st.field}; // R6 R7
  assign text_clear = st.clear_p;
  assign text_roll = st.roll_p;
  assign rgb = st.rgb;
  assign box_key_o = st.key;
  assign box_key_oe = st.key_oe;

  AST_START_CLEARS: assert property (@(posedge clk) disable iff (!nrst) // R21
    evt.start_text |=> text_clear && st.col == 5'h00 && st.row == st.base_row)
    else $error("start text did not clear and home");
  AST_HALT_HOLDS: assert property (@(posedge clk) disable iff (!nrst) // R20
    st.halted && !evt.start_text && !evt.resume_text |=> $stable(st.col) && $stable(st.row))
    else $error("pointer moved while halted");
  AST_RESUME: assert property (@(posedge clk) disable iff (!nrst) // R20
    evt.resume_text && !evt.start_text && !evt.other_chan |=> !st.halted)
    else $error("resume did not restart processing");
  AST_SCROLL_STEP: assert property (@(posedge clk) disable iff (!nrst) // R23
    frame_end && st.scroll != 4'h0 && !evt.cr && !evt.start_text
    |=> st.scroll == $past(st.scroll) - 4'h1)
    else $error("scroll did not step one line per frame");
  AST_CR_JUMP: assert property (@(posedge clk) disable iff (!nrst) // R23
    evt.cr && !st.halted && !evt.start_text && !evt.other_chan && !evt.resume_text
    && st.scroll != 4'h0 |=> st.scroll == l21d_pkg::SCROLL_LINES && text_roll)
    else $error("carriage return mid scroll did not jump");
  AST_SEMI_FLOAT: assert property (@(posedge clk) disable iff (!nrst) // R14
    dot_tick && show && in_h && in_v && in_text_rows && st.ctrl.ext_attr_en && pix.attr_semi
    |=> !box_key_oe)
    else $error("semi-transparent did not float keying");
  AST_ATTR_GATED: assert property (@(posedge clk) disable iff (!nrst) // R13
    dot_tick && !st.ctrl.ext_attr_en |=> box_key_oe)
    else $error("attribute acted while disabled");
  AST_HIDDEN: assert property (@(posedge clk) disable iff (!nrst) // R1 R18 R9
    dot_tick && (!show || !in_v) |=> !box_key_o && rgb == 3'h0)
    else $error("box shown outside its window");
  AST_BLUE_BOX: assert property (@(posedge clk) disable iff (!nrst) // R11
    dot_tick && show && in_h && in_v && in_text_rows && !fg && !st.ctrl.shadow
    |=> box_key_o && rgb == ($past(st.ctrl.blue_box) ? 3'h1 : 3'h0))
    else $error("box colour wrong");
  AST_DOT_RATE: assert property (@(posedge clk) disable iff (!nrst) // R24
    dot_tick |=> !dot_tick ##1 !dot_tick ##1 !dot_tick ##1 !dot_tick ##1 !dot_tick
    ##1 !dot_tick ##1 !dot_tick)
    else $error("dot rate above 12 MHz");
  AST_BRESP: assert property (@(posedge clk) disable iff (!nrst)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  COV_WRITE: cover property (@(posedge clk) disable iff (!nrst) wr_go ##1 bvalid);
  COV_ROLL: cover property (@(posedge clk) disable iff (!nrst) text_roll);
  COV_SEMI: cover property (@(posedge clk) disable iff (!nrst) !box_key_oe);
  COV_SHADOW: cover property (@(posedge clk) disable iff (!nrst)
    st.ctrl.shadow && box_key_o && rgb == 3'h0);
endmodule : l21d_display
`default_nettype wire

// ===== verif/l21d_tv_model.sv
// Purpose: television side: sync sources and box keying observer
// Assumes: short lines and fields so the box is reached quickly
// Notes: the box key wire floats whenever its enable is low
`timescale 1ns/100ps
`default_nettype none
module l21d_tv_model #(
  parameter int LINE_CLKS = 500,
  parameter int FIELD_LINES = 50
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic [2:0] rgb,
  input wire logic box_key_o,
  input wire logic box_key_oe,
  output logic video_hsync,
  output logic horiz_flyback_in,
  output logic video_vsync,
  output logic vert_in,
  output logic semi_seen,
  output logic blue_seen
);
  int clks;
  int lines;
  wire logic box_line;
  assign box_line = box_key_oe ? box_key_o : 1'bz;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clks <= 0;
      lines <= 0;
    end
    else
    begin
      clks <= (clks == LINE_CLKS - 1) ? 0 : clks + 1;
      if (clks == LINE_CLKS - 1)
        lines <= (lines == FIELD_LINES - 1) ? 0 : lines + 1;
    end
  end
  // flyback and vertical pin mirror the video syncs
  assign video_hsync = nrst && clks < 40;
  assign horiz_flyback_in = video_hsync;
  assign video_vsync = nrst && lines < 3;
  assign vert_in = video_vsync;
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      semi_seen <= 1'b0;
      blue_seen <= 1'b0;
    end
    else
    begin
      if (box_line === 1'bz)
        semi_seen <= 1'b1;
      if (rgb === 3'b001)
        blue_seen <= 1'b1;
    end
  end
endmodule : l21d_tv_model
`default_nettype wire

// ===== verif/testbench.sv
// Purpose: self-checking bench for the line 21 text display block
// Assumes: register offsets and event encoding of the block's package
// Notes: the tv model's short lines keep the video runs brief
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [31:0] d;
    logic [3:0] ch;
    logic [4:0] ln;
    logic gfx;
  } l21d_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic [3:0] wstrb = 4'hf, chan_sel, disp_row, glyph_col;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic line21_valid = 1'b0, clear = 1'b1, awready, wready, bvalid, arready, rvalid;
  logic video_hsync, horiz_flyback_in, video_vsync, vert_in, semi_seen, blue_seen;
  logic charset_graphics, text_clear, text_roll, box_key_o, box_key_oe;
  logic [1:0] bresp, rresp, r;
  logic [4:0] data_line, glyph_row;
  logic [5:0] disp_cell;
  logic [2:0] rgb;
  l21d_pkg::l21d_evt_t evt = '0;
  l21d_pkg::l21d_pix_t pix = '0;
  int errors = 0;
  int num_checks = 0;
  l21d_row_t rows [9] = '{
    '{32'h0000_0000, 4'h0, 5'h15, 1'b0}, '{32'h0000_0101, 4'h1, 5'h16, 1'b0},
    '{32'h0000_1002, 4'h2, 5'h15, 1'b1}, '{32'h0000_1083, 4'h3, 5'h15, 1'b0},
    '{32'h0000_0044, 4'h4, 5'h15, 1'b0}, '{32'h0000_0205, 4'h5, 5'h15, 1'b0},
    '{32'h0000_0406, 4'h6, 5'h15, 1'b0}, '{32'h0000_0807, 4'h7, 5'h15, 1'b0},
    '{32'h0000_2008, 4'h8, 5'h15, 1'b0}};

  always #5 clk = ~clk;

  l21d_display uut (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .video_hsync, .horiz_flyback_in, .video_vsync, .vert_in,
    .line21_valid, .evt, .pix, .chan_sel, .data_line, .charset_graphics, .disp_row,
    .disp_cell, .glyph_row, .glyph_col, .text_clear, .text_roll, .rgb, .box_key_o,
    .box_key_oe);

  l21d_tv_model tv (.clk, .nrst, .clear, .rgb, .box_key_o, .box_key_oe, .video_hsync,
    .horiz_flyback_in, .video_vsync, .vert_in, .semi_seen, .blue_seen);

  task automatic end_of_test();
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk

  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clk);
    while (!(awready && wready))
      @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1)
      @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (!arready)
      @(posedge clk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  // one event pulse; returns just after the edge that took it
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    evt <= l21d_pkg::l21d_evt_t'(e);
    @(posedge clk);
    evt <= '0;
    #1;
  endtask : pulse

  task automatic stat(input logic [3:0] row, input logic [4:0] col, input logic h,
    input logic [3:0] scr);
    axr(l21d_pkg::ADDR_STAT);
    chk("stat row", row, d[3:0]);
    chk("stat col", col, d[8:4]);
    chk("stat halted", h, d[16]);
    chk("stat scroll", scr, d[15:12]);
  endtask : stat

  task automatic watch(input logic semi, input logic blue);
    // let the last dot tick flush keying of the previous setting
    repeat (16) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (26000) @(posedge clk);
    #1;
    chk("semi_seen", semi, semi_seen);
    chk("blue_seen", blue, blue_seen);
  endtask : watch

  initial
  begin
    #900_000;
    errors++;
    end_of_test();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("chan_sel", 0, chan_sel);
    chk("data_line", 5'h15, data_line);
    chk("box_key_oe", 1, box_key_oe);
    axr(l21d_pkg::ADDR_CTRL);
    chk("ctrl", 0, d);
    axr(l21d_pkg::ADDR_HPOS);
    chk("hpos", 0, d);
    axr(l21d_pkg::ADDR_TEXT);
    chk("text", 32'h0000_000f, d);
    axr(32'h0000_0010);
    chk("rresp", l21d_pkg::RESP_DECERR, r);
    chk("rdata", 0, d);
    axw(32'h0000_0010, 32'h0000_0001);
    chk("bresp", l21d_pkg::RESP_DECERR, r);
    foreach (rows[i])
    begin
      axw(l21d_pkg::ADDR_CTRL, rows[i].d);
      repeat (2) @(posedge clk);
      #1;
      chk("bresp", l21d_pkg::RESP_OK, r);
      chk("chan_sel", rows[i].ch, chan_sel);
      chk("data_line", rows[i].ln, data_line);
      chk("charset_graphics", rows[i].gfx, charset_graphics);
      axr(l21d_pkg::ADDR_CTRL);
      chk("ctrl", rows[i].d, d);
    end
    axw(l21d_pkg::ADDR_CTRL, 32'h0000_0044);
    pulse(5'b00100);
    chk("text_clear", 1, text_clear);
    @(posedge clk);
    #1;
    chk("text_clear", 0, text_clear);
    repeat (3) pulse(5'b10000);
    pulse(5'b01000);
    stat(4'h1, 5'h00, 1'b0, 4'h0);
    repeat (2) pulse(5'b10000);
    pulse(5'b00001);
    pulse(5'b10000);
    pulse(5'b01000);
    stat(4'h1, 5'h02, 1'b1, 4'h0);
    pulse(5'b00010);
    pulse(5'b10000);
    stat(4'h1, 5'h03, 1'b0, 4'h0);
    repeat (40) pulse(5'b10000);
    stat(4'h1, 5'h1f, 1'b0, 4'h0);
    pulse(5'b00100);
    stat(4'h0, 5'h00, 1'b0, 4'h0);
    axw(l21d_pkg::ADDR_TEXT, 32'h0000_0023);
    pulse(5'b00100);
    stat(4'h2, 5'h00, 1'b0, 4'h0);
    repeat (2) pulse(5'b01000);
    stat(4'h4, 5'h00, 1'b0, 4'h0);
    pulse(5'b01000);
    chk("text_roll", 1, text_roll);
    stat(4'h4, 5'h00, 1'b0, l21d_pkg::SCROLL_LINES);
    pulse(5'b01000);
    chk("text_roll", 1, text_roll);
    axw(l21d_pkg::ADDR_TEXT, 32'h0000_000f);
    axw(l21d_pkg::ADDR_CTRL, 32'h0000_2844);
    line21_valid <= 1'b1;
    pix.attr_semi <= 1'b1;
    watch(1'b1, 1'b1);
    axw(l21d_pkg::ADDR_CTRL, 32'h0000_0844);
    watch(1'b0, 1'b1);
    @(posedge clk);
    line21_valid <= 1'b0;
    watch(1'b0, 1'b0);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("box_key_oe", 1, box_key_oe);
    axr(l21d_pkg::ADDR_CTRL);
    chk("ctrl", 0, d);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
